// >>> shared/paging_regs.vh
// Constants for the paging translation unit: entry fields, address split and cache geometry.
`ifndef PAGING_REGS_VH
`define PAGING_REGS_VH
// ----------------------------------------------------------------------
// Address split
// ----------------------------------------------------------------------
`define VA_WIDTH        32
`define PAGE_ADDR_WIDTH 20
`define OFFSET_WIDTH    12
`define DIR_IDX_HI      31
`define DIR_IDX_LO      22
`define TBL_IDX_HI      21
`define TBL_IDX_LO      12
`define IDX_WIDTH       10
// ----------------------------------------------------------------------
// Table entry fields
// ----------------------------------------------------------------------
`define ENT_PRESENT     0
`define ENT_WRITE       1
`define ENT_USER        2
`define ENT_WT          3
`define ENT_CD          4
`define ENT_ACCESSED    5
`define ENT_DIRTY       6
`define ENT_SW_LO       9
`define ENT_SW_HI       11
`define ENT_FRAME_LO    12
// ----------------------------------------------------------------------
// Translation cache geometry
// ----------------------------------------------------------------------
`define TC_WAYS         4
`define TC_SETS         16
`define TC_SET_BITS     4
`define TC_TAG_WIDTH    16
`define TC_ATTR_WIDTH   12
`endif

// >>> src/tc_set_lookup.v
// One-set lookup of the translation cache: hit detection and way select.
`timescale 1ns/10ps
`default_nettype none
`include "paging_regs.vh"
module tc_set_lookup (
    input  wire [4*`TC_TAG_WIDTH-1:0]    tags_in,
    input  wire [3:0]                    valid_in,
    input  wire [`TC_TAG_WIDTH-1:0]      tag_in,
    output reg                           hit_out,
    output reg  [1:0]                    way_out
);
    integer i;
    always @* begin
        hit_out = 1'b0;
        way_out = 2'h0;
        for (i = 0; i < `TC_WAYS; i = i + 1) begin
            if (valid_in[i] && tags_in[i*`TC_TAG_WIDTH +: `TC_TAG_WIDTH] == tag_in) begin
                hit_out = 1'b1;
                way_out = i[1:0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/access_check.v
// Page-level access rights check for user and supervisor accesses.
`timescale 1ns/10ps
`default_nettype none
`include "paging_regs.vh"
module access_check (
    input  wire [`TC_ATTR_WIDTH-1:0]     dir_attr_in,
    input  wire [`TC_ATTR_WIDTH-1:0]     tbl_attr_in,
    input  wire                          user_in,
    input  wire                          write_in,
    input  wire                          wp_in,
    output wire                          ok_out
);
    // Rights are the intersection of both levels.
    wire w_ok;
    wire u_ok;
    assign u_ok   = dir_attr_in[`ENT_USER] & tbl_attr_in[`ENT_USER];
    assign w_ok   = dir_attr_in[`ENT_WRITE] & tbl_attr_in[`ENT_WRITE];
    // Supervisor writes honour read-only pages only when write protect is set.
    assign ok_out = user_in ? (u_ok & (~write_in | w_ok))
                            : (~write_in | w_ok | ~wp_in);
endmodule
`default_nettype wire

// >>> src/paging_translation_unit.v
// Paging translation unit: translation cache, hardware table walk and protection.
//
// Behaviour
// - Enable clear: physical equals virtual, no translation, no rights check.
// - Reset clears the translation enable bit.
// - Page frames are 4K bytes, aligned on 4K boundaries.
// - Addresses are 32 bits: 20-bit page address, 12-bit offset passed through.
// - Two table levels, each 1024 entries of 32 bits.
// - Directory base field of 20 bits selects the one active directory.
// - Table walk runs in hardware on a cache miss.
// - Top 10 virtual bits index the directory.
// - Next 10 virtual bits index the page table.
// - Physical address is frame address joined with low 12 virtual bits.
// - A non-present directory or table entry aborts the access with a trap.
// - Entries carry write, user, cache disable, accessed, dirty, 3 software bits.
// - Protection distinguishes user and supervisor from entry rights bits.
// - Protection also uses the write protect status bit.
// - Cache returns page address with protection and replacement bits.
// - A cache lookup completes in one clock.
// - Cache is 4-way set associative with 64 entries.
// - After a miss walk, one cache entry is replaced with the new mapping.
// - Instruction invalidate bit, sampled only in ST_IDLE, clears every translation cache entry.
// - Enabled: page bit output is cache disable OR write-through, mode gated.
// - Disabled: page bit output stays deasserted.
`timescale 1ns/10ps
`default_nettype none
`include "paging_regs.vh"
module paging_translation_unit (
    input  wire                          mclk_in,
    input  wire                          sys_rst_in,
    // Configuration bits.
    input  wire                          translation_enable_bit_in,
    input  wire                          translation_enable_load_in,
    input  wire [`PAGE_ADDR_WIDTH-1:0]   dir_base_in,
    input  wire                          instr_invalidate_bit_in,
    input  wire                          write_protect_in,
    input  wire                          page_bit_output_select_in,
    // Processor request.
    input  wire                          req_valid_in,
    input  wire [`VA_WIDTH-1:0]          req_vaddr_in,
    input  wire                          req_write_in,
    input  wire                          req_user_in,
    output wire                          req_ready_out,
    output reg                           resp_valid_out,
    output reg  [`VA_WIDTH-1:0]          resp_paddr_out,
    output reg                           resp_trap_out,
    output reg                           resp_prot_fault_out,
    output reg                           page_table_bit_output_out,
    output wire                          translation_enable_out,
    // Table memory read port.
    output reg                           mem_req_out,
    output reg  [`VA_WIDTH-1:0]          mem_addr_out,
    input  wire                          mem_ack_in,
    input  wire [`VA_WIDTH-1:0]          mem_rdata_in
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_DIR  = 4'h2;
    localparam [3:0] ST_TBL  = 4'h4;
    localparam [3:0] ST_FILL = 4'h8;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg [`TC_TAG_WIDTH-1:0]    tag_mem   [0:`TC_SETS*`TC_WAYS-1];
    reg [`PAGE_ADDR_WIDTH-1:0] frame_mem [0:`TC_SETS*`TC_WAYS-1];
    reg [`TC_ATTR_WIDTH-1:0]   dattr_mem [0:`TC_SETS*`TC_WAYS-1];
    reg [`TC_ATTR_WIDTH-1:0]   tattr_mem [0:`TC_SETS*`TC_WAYS-1];
    reg [`TC_SETS*`TC_WAYS-1:0] valid_r;
    reg [2*`TC_SETS-1:0]        victim_r;
    reg                         enable_r;
    reg [3:0]                   state_r;
    reg [`VA_WIDTH-1:0]         vaddr_r;
    reg                         write_r;
    reg                         user_r;
    reg [`VA_WIDTH-1:0]         dir_ent_r;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function [5:0] slot;
        input [`TC_SET_BITS-1:0] set;
        input [1:0]              way;
        begin
            slot = {set, way};
        end
    endfunction

    // Entry address: table base page, index scaled by four bytes.
    function [`VA_WIDTH-1:0] entry_addr;
        input [`PAGE_ADDR_WIDTH-1:0] base;
        input [`IDX_WIDTH-1:0]       idx;
        begin
            entry_addr = {base, idx, 2'h0};
        end
    endfunction

    // ------------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------------
    wire [`TC_SET_BITS-1:0]  req_set;
    wire [`TC_TAG_WIDTH-1:0] req_tag;
    wire [4*`TC_TAG_WIDTH-1:0] set_tags;
    wire [3:0]               set_valid;
    wire                     hit;
    wire [1:0]               hit_way;
    wire [5:0]               hit_slot;
    wire [`TC_ATTR_WIDTH-1:0] hit_dattr;
    wire [`TC_ATTR_WIDTH-1:0] hit_tattr;
    wire                     hit_ok;

    assign req_set  = req_vaddr_in[`TBL_IDX_LO +: `TC_SET_BITS];
    assign req_tag  = req_vaddr_in[`DIR_IDX_HI:`TBL_IDX_LO+`TC_SET_BITS];
    assign set_tags = {tag_mem[slot(req_set, 2'h3)], tag_mem[slot(req_set, 2'h2)],
                       tag_mem[slot(req_set, 2'h1)], tag_mem[slot(req_set, 2'h0)]};
    assign set_valid = valid_r[{req_set, 2'h0} +: 4];

    // Combinational lookup keeps a hit to one clock.
    tc_set_lookup u_lookup (
        .tags_in  (set_tags),
        .valid_in (set_valid),
        .tag_in   (req_tag),
        .hit_out  (hit),
        .way_out  (hit_way)
    );

    assign hit_slot  = slot(req_set, hit_way);
    assign hit_dattr = dattr_mem[hit_slot];
    assign hit_tattr = tattr_mem[hit_slot];

    access_check u_check_hit (
        .dir_attr_in (hit_dattr),
        .tbl_attr_in (hit_tattr),
        .user_in     (req_user_in),
        .write_in    (req_write_in),
        .wp_in       (write_protect_in),
        .ok_out      (hit_ok)
    );

    // Rights of a freshly walked mapping.
    wire walk_ok;
    access_check u_check_walk (
        .dir_attr_in (dir_ent_r[`TC_ATTR_WIDTH-1:0]),
        .tbl_attr_in (mem_rdata_in[`TC_ATTR_WIDTH-1:0]),
        .user_in     (user_r),
        .write_in    (write_r),
        .wp_in       (write_protect_in),
        .ok_out      (walk_ok)
    );

    assign req_ready_out          = (state_r == ST_IDLE);
    assign translation_enable_out = enable_r;

    // ------------------------------------------------------------------
    // Enable bit
    // ------------------------------------------------------------------
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            enable_r <= 1'b0;
        end else if (translation_enable_load_in) begin
            enable_r <= translation_enable_bit_in;
        end
    end

    // ------------------------------------------------------------------
    // Control and walk
    // ------------------------------------------------------------------
    wire [`TC_SET_BITS-1:0] walk_set;
    wire [1:0]              walk_way;
    assign walk_set = vaddr_r[`TBL_IDX_LO +: `TC_SET_BITS];
    assign walk_way = victim_r[2*walk_set +: 2];

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_r                   <= ST_IDLE;
            valid_r                   <= {(`TC_SETS*`TC_WAYS){1'b0}};
            victim_r                  <= {(2*`TC_SETS){1'b0}};
            vaddr_r                   <= 32'h0;
            write_r                   <= 1'b0;
            user_r                    <= 1'b0;
            dir_ent_r                 <= 32'h0;
            resp_valid_out            <= 1'b0;
            resp_paddr_out            <= 32'h0;
            resp_trap_out             <= 1'b0;
            resp_prot_fault_out       <= 1'b0;
            page_table_bit_output_out <= 1'b0;
            mem_req_out               <= 1'b0;
            mem_addr_out              <= 32'h0;
        end else begin
            resp_valid_out      <= 1'b0;
            resp_trap_out       <= 1'b0;
            resp_prot_fault_out <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (instr_invalidate_bit_in) begin
                        valid_r <= {(`TC_SETS*`TC_WAYS){1'b0}};
                    end else if (req_valid_in && !enable_r) begin
                        resp_valid_out            <= 1'b1;
                        resp_paddr_out            <= req_vaddr_in;
                        page_table_bit_output_out <= 1'b0;
                    end else if (req_valid_in && hit) begin
                        resp_valid_out      <= 1'b1;
                        // Frame from the cache joined with the offset.
                        resp_paddr_out      <= {frame_mem[hit_slot],
                                                req_vaddr_in[`OFFSET_WIDTH-1:0]};
                        resp_prot_fault_out <= ~hit_ok;
                        page_table_bit_output_out <= page_bit_output_select_in &
                            (hit_tattr[`ENT_CD] | hit_tattr[`ENT_WT]);
                    end else if (req_valid_in) begin
                        vaddr_r      <= req_vaddr_in;
                        write_r      <= req_write_in;
                        user_r       <= req_user_in;
                        mem_req_out  <= 1'b1;
                        mem_addr_out <= entry_addr(dir_base_in,
                            req_vaddr_in[`DIR_IDX_HI:`DIR_IDX_LO]);
                        state_r      <= ST_DIR;
                    end
                end
                ST_DIR: begin
                    if (mem_ack_in) begin
                        dir_ent_r <= mem_rdata_in;
                        if (!mem_rdata_in[`ENT_PRESENT]) begin
                            mem_req_out    <= 1'b0;
                            resp_valid_out <= 1'b1;
                            resp_trap_out  <= 1'b1;
                            state_r        <= ST_IDLE;
                        end else begin
                            mem_addr_out <= entry_addr(
                                mem_rdata_in[`VA_WIDTH-1:`ENT_FRAME_LO],
                                vaddr_r[`TBL_IDX_HI:`TBL_IDX_LO]);
                            state_r      <= ST_TBL;
                        end
                    end
                end
                ST_TBL: begin
                    if (mem_ack_in) begin
                        mem_req_out    <= 1'b0;
                        resp_valid_out <= 1'b1;
                        state_r        <= ST_FILL;
                        if (!mem_rdata_in[`ENT_PRESENT]) begin
                            resp_trap_out <= 1'b1;
                            state_r       <= ST_IDLE;
                        end else begin
                            resp_paddr_out <= {mem_rdata_in[`VA_WIDTH-1:`ENT_FRAME_LO],
                                               vaddr_r[`OFFSET_WIDTH-1:0]};
                            resp_prot_fault_out <= ~walk_ok;
                            page_table_bit_output_out <= page_bit_output_select_in &
                                (mem_rdata_in[`ENT_CD] | mem_rdata_in[`ENT_WT]);
                            valid_r[slot(walk_set, walk_way)] <= 1'b1;
                            victim_r[2*walk_set +: 2] <= walk_way + 2'h1;
                        end
                    end
                end
                ST_FILL: begin
                    // One idle cycle lets the new entry settle before the next lookup.
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Entry payload writes; the full attribute field keeps all bits.
    always @(posedge mclk_in) begin
        if (state_r == ST_TBL && mem_ack_in && mem_rdata_in[`ENT_PRESENT]) begin
            tag_mem[slot(walk_set, walk_way)]   <=
                vaddr_r[`DIR_IDX_HI:`TBL_IDX_LO+`TC_SET_BITS];
            frame_mem[slot(walk_set, walk_way)] <= mem_rdata_in[`VA_WIDTH-1:`ENT_FRAME_LO];
            dattr_mem[slot(walk_set, walk_way)] <= dir_ent_r[`TC_ATTR_WIDTH-1:0];
            tattr_mem[slot(walk_set, walk_way)] <= mem_rdata_in[`TC_ATTR_WIDTH-1:0];
        end
    end
endmodule
`default_nettype wire

// >>> tb/ptu_mem_model.sv
// Table memory model: page directory and page tables answering entry reads.
`timescale 1ns/10ps
`default_nettype none
module ptu_mem_model #(
    parameter logic [19:0] DIR_PAGE = 20'h00010
) (
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        slow_in,
    input  wire logic        mem_req_in,
    input  wire logic [31:0] mem_addr_in,
    output logic             mem_ack_out,
    output logic [31:0]      mem_rdata_out
);
    logic [3:0]  wait_r;
    logic [31:0] word;
    // Directory entry i points at page table page {10'h001, i}; index 3 is absent.
    function automatic logic [31:0] pde(input logic [9:0] i);
        return (i == 10'h003) ? 32'h0 : {10'h001, i, 12'h007};
    endfunction
    // Frame and rights vary with both indices, cache bits with the table index only; index 5 is absent.
    function automatic logic [31:0] pte(input logic [9:0] i, input logic [9:0] j);
        logic [11:0] a;
        a = {7'h0, j[0], j[1] & j[2], i != 10'h002, j != 10'h006, 1'b1};
        return (j == 10'h005) ? 32'h0 : {j ^ 10'h2a5, i, a};
    endfunction
    always_comb begin
        if (mem_addr_in[31:12] == DIR_PAGE) begin
            word = pde(mem_addr_in[11:2]);
        end else begin
            word = pte(mem_addr_in[21:12], mem_addr_in[11:2]);
        end
    end
    // The data lines toggle whenever no answer is due, so a stale read shows up.
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mem_ack_out <= 1'b0;
            wait_r <= 4'h0;
            mem_rdata_out <= 32'h5a5a5a5a;
        end else if (mem_ack_out || !mem_req_in) begin
            mem_ack_out <= 1'b0;
            wait_r <= 4'h0;
            mem_rdata_out <= ~mem_rdata_out;
        end else if (wait_r >= (slow_in ? 4'h5 : 4'h0)) begin
            mem_ack_out <= 1'b1;
            mem_rdata_out <= word;
        end else begin
            wait_r <= wait_r + 4'h1;
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule
`default_nettype wire

// >>> tb/paging_translation_unit_props.sv
// Concurrent checks on the paging translation unit ports.
`timescale 1ns/10ps
`default_nettype none
module paging_translation_unit_props (
    input wire logic        mclk_in,
    input wire logic        sys_rst_in,
    input wire logic        translation_enable_load_in,
    input wire logic [19:0] dir_base_in,
    input wire logic        instr_invalidate_bit_in,
    input wire logic        req_valid_in,
    input wire logic [31:0] req_vaddr_in,
    input wire logic        req_ready_out,
    input wire logic        resp_valid_out,
    input wire logic [31:0] resp_paddr_out,
    input wire logic        resp_trap_out,
    input wire logic        resp_prot_fault_out,
    input wire logic        page_table_bit_output_out,
    input wire logic        translation_enable_out,
    input wire logic        mem_req_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic        mem_ack_in,
    input wire logic [31:0] mem_rdata_in
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    logic [31:0] va_r;
    wire         take = req_valid_in && req_ready_out && !instr_invalidate_bit_in;
    wire         dir_rd = mem_req_out && (mem_addr_out[31:12] == dir_base_in);
    // Address of the request in flight; a walk blocks new takes, so it holds.
    always @(posedge mclk_in) begin
        if (take) begin
            va_r <= req_vaddr_in;
        end
    end
    sequence s_take_off;
        take && !translation_enable_out && !translation_enable_load_in;
    endsequence
    sequence s_dir_ack;
        mem_ack_in && dir_rd;
    endsequence
    sequence s_tbl_ack;
        mem_ack_in && mem_req_out && !dir_rd;
    endsequence
    a_pass_through: assert property (s_take_off |=> resp_valid_out
        && resp_paddr_out == $past(req_vaddr_in) && !resp_trap_out
        && !resp_prot_fault_out && !page_table_bit_output_out) else $error("pass-through");
    a_reset_clears: assert property ($past(sys_rst_in) |-> !translation_enable_out
        && !mem_req_out && !resp_valid_out) else $error("reset state");
    a_one_clock: assert property (take |=> resp_valid_out != mem_req_out)
        else $error("lookup latency");
    a_dir_entry: assert property ($rose(mem_req_out) |->
        mem_addr_out == {dir_base_in, va_r[31:22], 2'b00}) else $error("dir address");
    a_tbl_entry: assert property (s_dir_ack ##0 mem_rdata_in[0] |=> mem_req_out
        && mem_addr_out == {$past(mem_rdata_in[31:12]), va_r[21:12], 2'b00})
        else $error("table address");
    a_dir_trap: assert property (s_dir_ack ##0 !mem_rdata_in[0] |=> resp_valid_out
        && resp_trap_out && !mem_req_out) else $error("directory trap");
    a_walk_result: assert property (s_tbl_ack |=> resp_valid_out && !mem_req_out
        && resp_trap_out == !$past(mem_rdata_in[0]) && !(resp_trap_out && resp_prot_fault_out)
        && (resp_trap_out || resp_paddr_out == {$past(mem_rdata_in[31:12]), va_r[11:0]}))
        else $error("walk result");
    a_offset_kept: assert property (resp_valid_out && !resp_trap_out |->
        resp_paddr_out[11:0] == va_r[11:0]) else $error("offset");
    a_walk_bound: assert property ($rose(mem_req_out) |-> ##[1:40] !mem_req_out)
        else $error("walk too long");
    a_busy_walk: assert property (mem_req_out |-> !req_ready_out)
        else $error("ready during walk");
    sequence s_flush;
        instr_invalidate_bit_in && req_ready_out;
    endsequence
    a_flush_miss: assert property (s_flush ##1 take && translation_enable_out |=> mem_req_out)
        else $error("flush miss");
endmodule
bind paging_translation_unit paging_translation_unit_props u_props (.mclk_in, .sys_rst_in,
    .translation_enable_load_in, .dir_base_in, .instr_invalidate_bit_in, .req_valid_in,
    .req_vaddr_in, .req_ready_out, .resp_valid_out, .resp_paddr_out, .resp_trap_out,
    .resp_prot_fault_out, .page_table_bit_output_out, .translation_enable_out, .mem_req_out,
    .mem_addr_out, .mem_ack_in, .mem_rdata_in);
`default_nettype wire

// >>> tb/paging_translation_unit_test.sv
// Self-checking bench for the paging translation unit.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module paging_translation_unit_test;
    logic        mclk_in = 1'b0, sys_rst_in = 1'b1, slow = 1'b0;
    logic        translation_enable_bit_in = 1'b0, translation_enable_load_in = 1'b0;
    logic        instr_invalidate_bit_in = 1'b0, write_protect_in = 1'b0;
    logic        page_bit_output_select_in = 1'b0, req_valid_in = 1'b0;
    logic        req_write_in = 1'b0, req_user_in = 1'b0;
    logic [31:0] req_vaddr_in = 32'h0, r, va;
    logic [19:0] dir_base_in = 20'h00010;
    wire         req_ready_out, resp_valid_out, resp_trap_out, resp_prot_fault_out;
    wire         page_table_bit_output_out, translation_enable_out, mem_req_out, mem_ack_in;
    wire  [31:0] resp_paddr_out, mem_addr_out, mem_rdata_in;
    int          error_cnt = 0, checks = 0, walks = 0, seed = 26;
    logic [34:0] expq[$];
    // Cache walk script: bit 4 is the expected walk count, bits 3:0 the directory index.
    logic [4:0]  tl [0:12] = '{5'h10, 5'h11, 5'h12, 5'h14, 5'h00, 5'h01, 5'h02, 5'h04,
                               5'h16, 5'h01, 5'h10, 5'h02, 5'h11};
    always #2 mclk_in = ~mclk_in;
    paging_translation_unit dut (.mclk_in, .sys_rst_in, .translation_enable_bit_in,
        .translation_enable_load_in, .dir_base_in, .instr_invalidate_bit_in, .write_protect_in,
        .page_bit_output_select_in, .req_valid_in, .req_vaddr_in, .req_write_in, .req_user_in,
        .req_ready_out, .resp_valid_out, .resp_paddr_out, .resp_trap_out, .resp_prot_fault_out,
        .page_table_bit_output_out, .translation_enable_out, .mem_req_out, .mem_addr_out,
        .mem_ack_in, .mem_rdata_in);
    ptu_mem_model mem (.mclk_in, .sys_rst_in, .slow_in(slow), .mem_req_in(mem_req_out),
        .mem_addr_in(mem_addr_out), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
    // Expected {trap, fault, page bit, paddr}, worked out from the table contents.
    function automatic logic [34:0] expect_of(input logic [31:0] a, input logic w, u);
        logic [31:0] d, t;
        d = mem.pde(a[31:22]);
        t = mem.pte(a[31:22], a[21:12]);
        if (!translation_enable_bit_in) return {3'b000, a};
        if (!d[0] || !t[0]) return {3'b100, a};
        return {1'b0, (u && !(d[2] & t[2])) || (w && !(d[1] & t[1]) && (u || write_protect_in)),
            page_bit_output_select_in & (t[4] | t[3]), t[31:12], a[11:0]};
    endfunction
    // Called just after a rising edge; returns at the edge that takes the request.
    task automatic issue(input logic [31:0] a, input logic w, u);
        req_valid_in <= 1'b1;
        req_vaddr_in <= a;
        req_write_in <= w;
        req_user_in <= u;
        do @(negedge mclk_in); while (req_ready_out !== 1'b1);
        @(posedge mclk_in);
        expq.push_back(expect_of(a, w, u));
    endtask
    task automatic drain();
        req_valid_in <= 1'b0;
        while (expq.size() != 0 || req_ready_out !== 1'b1) @(negedge mclk_in);
        @(posedge mclk_in);
    endtask
    task automatic load(input logic v);
        translation_enable_bit_in <= v;
        translation_enable_load_in <= 1'b1;
        @(posedge mclk_in);
        translation_enable_load_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    // Called just after a rising edge while idle; one-cycle invalidate pulse.
    task automatic flush();
        instr_invalidate_bit_in <= 1'b1;
        @(posedge mclk_in);
        instr_invalidate_bit_in <= 1'b0;
    endtask
    task automatic touch(input logic [9:0] i, input int dw);
        int w0;
        w0 = walks;
        issue({i, 10'h010, 12'h123}, 1'b0, 1'b0);
        drain();
        `CHK("walks", dw, walks - w0)
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mem_req_out) walks++;
    // Responses are matched in order against the oldest expectation.
    always @(negedge mclk_in) begin : monitor
        logic [34:0] e;
        if (resp_valid_out === 1'b1) begin
            `CHK("queue", 1'b1, expq.size() != 0)
            e = expq.pop_front();
            `CHK("trap", e[34], resp_trap_out)
            `CHK("fault", e[33], resp_prot_fault_out)
            if (!e[34]) begin
                `CHK("paddr", e[31:0], resp_paddr_out)
                `CHK("ptb", e[32], page_table_bit_output_out)
            end
        end
    end
    initial begin
        #80000;
        error_cnt++;
        results();
    end
    task automatic pass_through();
        repeat (6) begin
            r = $random(seed);
            issue(r, r[0], r[1]);
        end
        drain();
        $display("test pass_through done");
    endtask
    initial begin
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(negedge mclk_in);
        `CHK("enable", 1'b0, translation_enable_out)
        @(posedge mclk_in);
        pass_through();
        load(1'b1);
        `CHK("enable", 1'b1, translation_enable_out)
        for (int m = 0; m < 4; m++) begin
            write_protect_in <= m[0];
            page_bit_output_select_in <= m[1];
            repeat (10) begin
                r = $random(seed);
                va = {7'h00, r[2:0], (r[4:3] == 2'b00) ? 10'h005 + {9'h0, r[5]} : r[15:6], r[27:16]};
                slow <= r[30];
                issue(va, r[28], r[29]);
                issue(va, r[28], r[29]);
            end
            drain();
        end
        $display("test translate done");
        // Four ways fill set 0, then round-robin eviction order is probed.
        flush();
        foreach (tl[k]) touch({6'h00, tl[k][3:0]}, tl[k][4]);
        flush();
        touch(10'h001, 1);
        $display("test cache done");
        results();
    end
endmodule
`default_nettype wire
